// >>> include/cta_regs.svh
`ifndef CTA_REGS_SVH
`define CTA_REGS_SVH

// ==========================================
// Register map (byte addresses)
`define CTA_A_GPR_LAST 6'h1c
`define CTA_A_FLAGS 6'h20
`define CTA_A_EXT 6'h24
`define CTA_A_CMD 6'h28
`define CTA_A_STAT 6'h2c

// ==========================================
// Flag and status bit positions
`define CTA_F_C 0
`define CTA_F_V 1
`define CTA_F_Z 2
`define CTA_F_N 3
`define CTA_F_H 5
`define CTA_S_BUSY 0
`define CTA_S_ILL 1

// ==========================================
// Reset values and masks
`define CTA_FLAGS_RST 8'h00
`define CTA_FLAGS_MASK 8'h2f
`define CTA_GPR_RST 32'h0000_0000

// ==========================================
// State counts and stack pointer step
`define CTA_ST_BASIC 5'h01
`define CTA_ST_MULU_B 5'h0c
`define CTA_ST_MULU_W 5'h14
`define CTA_ST_MULS_B 5'h0d
`define CTA_ST_MULS_W 5'h15
`define CTA_ST_MULTI_BASE 5'h03
`define CTA_ST_MULTI_PER 5'h02
`define CTA_SP_STEP 32'h0000_0004

`define CTA_MEM_BYTES 256

`endif

// >>> include/cta_pkg.sv
`default_nettype none

package cta_pkg;

   typedef enum logic [4:0] {
      OP_NOP, OP_XFER_IMM, OP_XFER_REG, OP_XFER_LOAD, OP_XFER_STORE,
      OP_PUSH, OP_POP, OP_RESTORE_MULTI, OP_SAVE_MULTI, OP_ADDR_ADD,
      OP_ADDR_SUB, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB, OP_MUL_U, OP_MUL_S,
      OP_MUL_ACC
   } cta_op_e;

   typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} cta_size_e;
   typedef enum logic [1:0] {AM_IND, AM_DISP, AM_STEP, AM_ABS} cta_amode_e;
   typedef enum logic [1:0] {FW_8, FW_16, FW_24, FW_32} cta_fwidth_e;

   typedef struct packed {
      logic [1:0] k;
      cta_fwidth_e fw;
      cta_amode_e am;
      logic [3:0] rs;
      logic [3:0] rd;
      cta_size_e sz;
      cta_op_e op;
   } cta_cmd_s;

   typedef struct packed {
      logic [31:0] res;
      logic [7:0] flags;
   } cta_alu_s;

endpackage

`default_nettype wire

// >>> verilog/cta_alu.sv
`include "cta_regs.svh"
`default_nettype none

module cta_alu
   import cta_pkg::*;
(
   input wire cta_op_e op,
   input wire cta_size_e sz,
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic [7:0] flags_in,
   output cta_alu_s out
);

   function automatic logic [1:0] nz(cta_size_e s, logic [31:0] v);
      case (s)
         SZ_B: nz = {v[7], v[7:0] == 8'h00};
         SZ_W: nz = {v[15], v[15:0] == 16'h0000};
         default: nz = {v[31], v == 32'h0000_0000};
      endcase
   endfunction

   logic [15:0] pu8;
   logic [31:0] pu16;
   logic signed [15:0] ps8;
   logic signed [31:0] ps16;
   logic lo_adj;
   logic hi_adj;
   logic [7:0] adj;

   assign pu8 = a[7:0] * b[7:0];
   assign pu16 = a[15:0] * b[15:0];
   assign ps8 = $signed(a[7:0]) * $signed(b[7:0]);
   assign ps16 = $signed(a[15:0]) * $signed(b[15:0]);

   always_comb
   begin
      out.res = a;
      out.flags = flags_in;
      lo_adj = 1'b0;
      hi_adj = 1'b0;
      adj = 8'h00;
      case (op)
         OP_XFER_IMM, OP_XFER_REG, OP_XFER_LOAD, OP_XFER_STORE,
         OP_PUSH, OP_POP:
         begin
            out.res = b;
            {out.flags[`CTA_F_N], out.flags[`CTA_F_Z]} = nz(sz, b);
            out.flags[`CTA_F_V] = 1'b0;
         end
         OP_DEC_ADJ_ADD:
         begin
            // H and V keep old values: software must not rely on them
            lo_adj = flags_in[`CTA_F_H] || (a[3:0] > 4'h9);
            hi_adj = flags_in[`CTA_F_C] || (a[7:0] > 8'h99);
            adj = {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
            out.res = {24'h00_0000, 8'(a[7:0] + adj)};
            out.flags[`CTA_F_C] = hi_adj;
            {out.flags[`CTA_F_N], out.flags[`CTA_F_Z]} =
               nz(SZ_B, out.res);
         end
         OP_DEC_ADJ_SUB:
         begin
            adj = {flags_in[`CTA_F_C] ? 4'h6 : 4'h0,
                   flags_in[`CTA_F_H] ? 4'h6 : 4'h0};
            out.res = {24'h00_0000, 8'(a[7:0] - adj)};
            {out.flags[`CTA_F_N], out.flags[`CTA_F_Z]} =
               nz(SZ_B, out.res);
         end
         OP_MUL_U:
            out.res = (sz == SZ_B) ? {16'h0000, pu8} : pu16;
         OP_MUL_S:
         begin
            out.res = (sz == SZ_B) ? {16'h0000, ps8} : ps16;
            {out.flags[`CTA_F_N], out.flags[`CTA_F_Z]} =
               nz((sz == SZ_B) ? SZ_W : SZ_L, out.res);
         end
         default:
            out.res = a;
      endcase
   end

endmodule

`default_nettype wire

// >>> verilog/cta_core.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "cta_regs.svh"
`default_nettype none

module cta_core
   import cta_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   output logic busy
);

   // ==========================================
   // State
   logic [31:0] gpr_r [8];
   logic [7:0] mem_r [`CTA_MEM_BYTES];
   cta_cmd_s cmd_r;
   logic [31:0] ext_r;
   logic [7:0] flags_r;
   logic busy_r;
   logic ill_r;
   logic [4:0] cnt_r;
   logic [31:0] rdata_r;
   logic [31:0] sp0_r;

   assign rdata = rdata_r;
   assign busy = busy_r;

   // ==========================================
   // Helpers
   function automatic logic [31:0] rreg(cta_size_e s, logic [3:0] i);
      logic [31:0] g;
      g = gpr_r[i[2:0]];
      case (s)
         SZ_B: rreg = {24'h00_0000, i[3] ? g[7:0] : g[15:8]};
         SZ_W: rreg = {16'h0000, i[3] ? g[31:16] : g[15:0]};
         default: rreg = g;
      endcase
   endfunction

   function automatic logic [31:0] wreg(cta_size_e s, logic [3:0] i,
                                        logic [31:0] o, logic [31:0] v);
      case (s)
         SZ_B: wreg = i[3] ? {o[31:8], v[7:0]}
                           : {o[31:16], v[7:0], o[7:0]};
         SZ_W: wreg = i[3] ? {v[15:0], o[15:0]}
                           : {o[31:16], v[15:0]};
         default: wreg = v;
      endcase
   endfunction

   // 8-bit absolute addresses land in the top page, as the core expects
   function automatic logic [31:0] fext(cta_fwidth_e w, logic abs_f,
                                        logic [31:0] v);
      case (w)
         FW_8: fext = abs_f ? {24'hff_ffff, v[7:0]}
                            : {{24{v[7]}}, v[7:0]};
         FW_16: fext = {{16{v[15]}}, v[15:0]};
         FW_24: fext = {8'h00, v[23:0]};
         default: fext = v;
      endcase
   endfunction

   // ==========================================
   // Decode
   cta_cmd_s cmd_in;
   cta_alu_s alu;
   cta_size_e xsz;
   cta_size_e dsz;
   logic acc;
   logic multi;
   logic commit;
   logic step;
   logic dst_we;
   logic [2:0] nreg;
   logic [2:0] k_idx;
   logic [2:0] areg;
   logic [2:0] nb;
   logic [4:0] tot;
   logic [4:0] k_off;
   logic [31:0] nb32;
   logic [31:0] abase;
   logic [31:0] ea;
   logic [7:0] ea8;
   logic [31:0] mword;
   logic [31:0] mval;
   logic [31:0] bval;
   logic [31:0] wval;
   logic [31:0] kval;
   logic [31:0] wsh;
   logic mwe;

   assign cmd_in = cta_cmd_s'(wdata[20:0]);
   assign acc = wr_stb && !busy_r && addr == `CTA_A_CMD;
   assign multi = cmd_r.op inside {OP_RESTORE_MULTI, OP_SAVE_MULTI};
   assign nreg = 3'(cmd_r.rd[2:0] - cmd_r.rs[2:0] + 3'h1);
   assign k_off = 5'(cnt_r - 5'h02);
   assign k_idx = k_off[3:1];
   assign commit = busy_r && cnt_r == 5'(tot - 5'h01);
   assign step = busy_r && multi && cnt_r >= 5'h02 && !cnt_r[0]
                 && k_idx < nreg;
   assign xsz = multi ? SZ_L : cmd_r.sz;
   assign nb = (xsz == SZ_B) ? 3'h1 : (xsz == SZ_W) ? 3'h2 : 3'h4;
   assign nb32 = {29'h0, nb};
   assign areg = (cmd_r.op == OP_XFER_STORE) ? cmd_r.rd[2:0]
                                             : cmd_r.rs[2:0];
   assign abase = gpr_r[areg];
   assign kval = (cmd_r.k == 2'h0) ? 32'h0000_0001 :
                 (cmd_r.k == 2'h1) ? 32'h0000_0002 : 32'h0000_0004;
   assign dst_we = cmd_r.op inside {OP_XFER_IMM, OP_XFER_REG,
      OP_XFER_LOAD, OP_POP, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB,
      OP_MUL_U, OP_MUL_S};

   always_comb
   begin
      case (cmd_r.op)
         OP_RESTORE_MULTI, OP_SAVE_MULTI:
            tot = `CTA_ST_MULTI_BASE + `CTA_ST_MULTI_PER * {2'h0, nreg};
         OP_MUL_U: tot = (cmd_r.sz == SZ_B) ? `CTA_ST_MULU_B
                                            : `CTA_ST_MULU_W;
         OP_MUL_S: tot = (cmd_r.sz == SZ_B) ? `CTA_ST_MULS_B
                                            : `CTA_ST_MULS_W;
         default: tot = `CTA_ST_BASIC;
      endcase
   end

   always_comb
   begin
      case (cmd_r.op)
         OP_MUL_U, OP_MUL_S: dsz = (cmd_r.sz == SZ_B) ? SZ_W : SZ_L;
         OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB: dsz = SZ_B;
         default: dsz = cmd_r.sz;
      endcase
   end

   always_comb
   begin
      case (cmd_r.op)
         OP_XFER_LOAD, OP_XFER_STORE:
            case (cmd_r.am)
               AM_IND: ea = abase;
               AM_DISP: ea = abase + fext(cmd_r.fw, 1'b0, ext_r);
               AM_STEP: ea = (cmd_r.op == OP_XFER_STORE) ? abase - nb32
                                                         : abase;
               default: ea = fext(cmd_r.fw, 1'b1, ext_r);
            endcase
         OP_PUSH, OP_SAVE_MULTI: ea = gpr_r[7] - nb32;
         OP_POP, OP_RESTORE_MULTI: ea = gpr_r[7];
         default: ea = abase;
      endcase
   end

   // Only the low byte of an address reaches the small data store
   assign ea8 = ea[7:0];
   assign mword = {mem_r[ea8], mem_r[8'(ea8 + 8'h01)],
                   mem_r[8'(ea8 + 8'h02)], mem_r[8'(ea8 + 8'h03)]};
   assign mval = (xsz == SZ_B) ? {24'h00_0000, mword[31:24]} :
                 (xsz == SZ_W) ? {16'h0000, mword[31:16]} : mword;

   always_comb
   begin
      case (cmd_r.op)
         OP_XFER_IMM: bval = ext_r;
         OP_XFER_LOAD, OP_POP: bval = mval;
         OP_PUSH: bval = rreg(cmd_r.sz, cmd_r.rd);
         default: bval = rreg(cmd_r.sz, cmd_r.rs);
      endcase
   end

   assign wval = (cmd_r.op == OP_SAVE_MULTI)
                 ? gpr_r[3'(cmd_r.rs[2:0] + k_idx)] : bval;
   // Left-justify the operand so its first byte lands at ea
   assign wsh = wval << {3'h4 - nb, 3'h0};
   assign mwe = (commit && cmd_r.op inside {OP_XFER_STORE, OP_PUSH})
                || (step && cmd_r.op == OP_SAVE_MULTI);

   cta_alu u_alu (
      .op(cmd_r.op),
      .sz(cmd_r.sz),
      .a(rreg(dsz, cmd_r.rd)),
      .b(bval),
      .flags_in(flags_r),
      .out(alu)
   );

   // ==========================================
   // Command sequencing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_r <= '0;
         busy_r <= 1'b0;
         ill_r <= 1'b0;
         cnt_r <= 5'h00;
         sp0_r <= 32'h0000_0000;
      end
      else if (acc)
      begin
         cmd_r <= cmd_in;
         if (cmd_in.op >= OP_MUL_ACC)
            ill_r <= 1'b1;
         else
         begin
            ill_r <= 1'b0;
            busy_r <= 1'b1;
            cnt_r <= 5'h00;
            sp0_r <= gpr_r[7];
         end
      end
      else if (busy_r)
      begin
         cnt_r <= 5'(cnt_r + 5'h01);
         if (commit)
            busy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_r <= 32'h0000_0000;
      else if (wr_stb && !busy_r && addr == `CTA_A_EXT)
         ext_r <= wdata;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_r <= `CTA_FLAGS_RST;
      else if (wr_stb && !busy_r && addr == `CTA_A_FLAGS)
         flags_r <= wdata[7:0] & `CTA_FLAGS_MASK;
      else if (commit)
         flags_r <= alu.flags & `CTA_FLAGS_MASK;
   end

   // ==========================================
   // Register file
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 8; i++)
            gpr_r[i] <= `CTA_GPR_RST;
      end
      else
      begin
         if (wr_stb && !busy_r && addr <= `CTA_A_GPR_LAST
             && addr[1:0] == 2'h0)
            gpr_r[addr[4:2]] <= wdata;
         if (step && cmd_r.op == OP_RESTORE_MULTI)
         begin
            gpr_r[7] <= gpr_r[7] + `CTA_SP_STEP;
            gpr_r[3'(cmd_r.rd[2:0] - k_idx)] <= mval;
         end
         if (step && cmd_r.op == OP_SAVE_MULTI)
            gpr_r[7] <= ea;
         if (commit)
         begin
            case (cmd_r.op)
               OP_XFER_LOAD:
                  if (cmd_r.am == AM_STEP)
                     gpr_r[areg] <= abase + nb32;
               OP_XFER_STORE:
                  if (cmd_r.am == AM_STEP)
                     gpr_r[areg] <= ea;
               OP_PUSH: gpr_r[7] <= ea;
               OP_POP: gpr_r[7] <= gpr_r[7] + nb32;
               OP_ADDR_ADD: gpr_r[cmd_r.rd[2:0]] <=
                  gpr_r[cmd_r.rd[2:0]] + kval;
               OP_ADDR_SUB: gpr_r[cmd_r.rd[2:0]] <=
                  gpr_r[cmd_r.rd[2:0]] - kval;
               default: ;
            endcase
            // Destination written last so it wins over a step update
            if (dst_we)
               gpr_r[cmd_r.rd[2:0]] <= wreg(dsz, cmd_r.rd,
                  gpr_r[cmd_r.rd[2:0]], alu.res);
         end
      end
   end

   // Data store, big-endian; contents undefined after reset
   always_ff @(posedge clk)
   begin
      if (mwe)
         for (int i = 0; i < 4; i++)
            if (3'(i) < nb)
               mem_r[8'(ea8 + 8'(i))] <= wsh[31 - 8 * i -: 8];
   end

   // ==========================================
   // Read port
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 32'h0000_0000;
      else if (!rd_stb)
         rdata_r <= 32'h0000_0000;
      else if (addr <= `CTA_A_GPR_LAST && addr[1:0] == 2'h0)
         rdata_r <= gpr_r[addr[4:2]];
      else if (addr == `CTA_A_FLAGS)
         rdata_r <= {24'h00_0000, flags_r};
      else if (addr == `CTA_A_EXT)
         rdata_r <= ext_r;
      else if (addr == `CTA_A_CMD)
         rdata_r <= {11'h000, cmd_r};
      else if (addr == `CTA_A_STAT)
         rdata_r <= {30'h0000_0000, ill_r, busy_r};
      else
         rdata_r <= 32'h0000_0000;
   end

   // ==========================================
   // Checks
   a_move_flags:
   assert property (@(posedge clk) disable iff (!rst_n)
      commit && cmd_r.op inside {OP_XFER_IMM, OP_XFER_REG, OP_XFER_LOAD,
                                 OP_XFER_STORE, OP_PUSH, OP_POP}
      |=> !flags_r[`CTA_F_V]
          && flags_r[`CTA_F_C] == $past(flags_r[`CTA_F_C])
          && flags_r[`CTA_F_H] == $past(flags_r[`CTA_F_H]))
   else $error("move changed carry or half-carry or kept overflow");

   a_addr_add_flags:
   assert property (@(posedge clk) disable iff (!rst_n)
      commit && cmd_r.op inside {OP_ADDR_ADD, OP_ADDR_SUB}
      |=> $stable(flags_r))
   else $error("address add or subtract touched the flags");

   a_restore_states:
   assert property (@(posedge clk) disable iff (!rst_n)
      $rose(busy_r) && cmd_r.op == OP_RESTORE_MULTI && nreg == 3'h2
      |-> busy_r [*7] ##1 !busy_r)
   else $error("two-register restore not seven states");

   a_restore_sp:
   assert property (@(posedge clk) disable iff (!rst_n)
      commit && cmd_r.op == OP_RESTORE_MULTI
      |=> gpr_r[7] == sp0_r + {27'h0, nreg, 2'h0})
   else $error("restore left stack pointer wrong");

   a_save_sp:
   assert property (@(posedge clk) disable iff (!rst_n)
      commit && cmd_r.op == OP_SAVE_MULTI
      |=> gpr_r[7] == sp0_r - {27'h0, nreg, 2'h0} && $stable(flags_r))
   else $error("save left stack pointer or flags wrong");

   a_mul_u_flags:
   assert property (@(posedge clk) disable iff (!rst_n)
      $rose(busy_r) && cmd_r.op == OP_MUL_U && cmd_r.sz == SZ_B
      |-> ##11 (busy_r && $stable(flags_r)) ##1 !busy_r && $stable(flags_r))
   else $error("unsigned byte multiply timing or flags wrong");

   a_dec_adj_carry:
   assert property (@(posedge clk) disable iff (!rst_n)
      commit && cmd_r.op == OP_DEC_ADJ_ADD && flags_r[`CTA_F_C]
      |=> flags_r[`CTA_F_C])
   else $error("decimal adjust lost a carry");

   a_mac_refused:
   assert property (@(posedge clk) disable iff (!rst_n)
      acc && cmd_in.op == OP_MUL_ACC
      |=> ill_r && !busy_r && $stable(flags_r))
   else $error("multiply-accumulate command was not refused");

   a_post_inc_step:
   assert property (@(posedge clk) disable iff (!rst_n)
      commit && cmd_r.op == OP_XFER_LOAD && cmd_r.am == AM_STEP
      && cmd_r.sz == SZ_B && areg != cmd_r.rd[2:0]
      |=> gpr_r[$past(areg)] == $past(abase) + 32'h0000_0001)
   else $error("byte post-increment did not add one");

   a_flags_read:
   assert property (@(posedge clk) disable iff (!rst_n)
      rd_stb && addr == `CTA_A_FLAGS
      |=> rdata_r == {24'h00_0000, $past(flags_r)})
   else $error("flags read returned wrong data");

endmodule

`default_nettype wire

// >>> bench/cpu_transfer_arith_semantics_test.sv
`include "cta_regs.svh"
`default_nettype none

module cpu_transfer_arith_semantics_test
   import cta_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================
   // Stimulus and design
   localparam logic [5:0] a_fl = `CTA_A_FLAGS;
   localparam logic [5:0] a_ext = `CTA_A_EXT;
   localparam logic [5:0] a_cmd = `CTA_A_CMD;
   localparam logic [5:0] a_st = `CTA_A_STAT;
   logic clk;
   logic rst_n;
   logic [5:0] addr;
   logic [31:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic [31:0] rdata;
   logic busy;
   int n_errors;
   int cmp_count;

   cta_core i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .busy(busy));

   // ==========================================
   // Bus and checking tasks
   task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
      cmp_count++;
      if (got !== ex)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
         n_errors++;
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'h1;
      @(posedge clk);
      wr_stb <= 1'h0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'h1;
      @(posedge clk);
      rd_stb <= 1'h0;
      #1;
      d = rdata;
   endtask

   task automatic rchk(input string nm, input logic [5:0] a,
      input logic [31:0] ex);
      logic [31:0] d;
      rd(a, d);
      chk(nm, ex, d);
   endtask

   // Bounded so a stuck busy cannot hang the run
   task automatic idle(output int n);
      n = 0;
      #1;
      while (busy === 1'h1 && n < 64)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic go(input cta_op_e op, input cta_size_e sz,
      input logic [3:0] d, input logic [3:0] s, input logic [1:0] am,
      input logic [1:0] fw, input logic [1:0] k, input int st);
      int n;
      wr(a_cmd, {11'h0, k, fw, am, s, d, sz, op});
      idle(n);
      chk("busy cycles", 32'(st), 32'(n));
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         rchk("gpr reset", 6'(i * 4), `CTA_GPR_RST);
      rchk("flags reset", a_fl, 32'h0);
      rchk("status reset", a_st, 32'h0);
      rchk("unmapped", 6'h30, 32'h0);
      @(posedge clk);
      #1;
      chk("rdata idle", 32'h0, rdata);
      wr(a_fl, 32'hff);
      rchk("flags mask", a_fl, 32'h2f);
   endtask

   task automatic t_move;
      wr(a_fl, 32'h23);
      wr(a_ext, 32'h80);
      go(OP_XFER_IMM, SZ_B, 4'h0, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      rchk("high byte", 6'h00, 32'h8000);
      rchk("flags byte", a_fl, 32'h29);
      wr(a_ext, 32'h0);
      go(OP_XFER_IMM, SZ_W, 4'h8, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      rchk("upper half", 6'h00, 32'h8000);
      rchk("flags word", a_fl, 32'h25);
      wr(a_ext, 32'h8765_4321);
      go(OP_XFER_IMM, SZ_L, 4'h1, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      wr(a_fl, 32'h02);
      go(OP_XFER_REG, SZ_L, 4'h2, 4'h1, 2'h0, 2'h0, 2'h0, 1);
      rchk("reg move", 6'h08, 32'h8765_4321);
      rchk("flags reg", a_fl, 32'h08);
      wr(6'h1c, 32'h80);
      go(OP_PUSH, SZ_L, 4'h2, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      rchk("sp push", 6'h1c, 32'h7c);
      wr(a_fl, 32'h22);
      go(OP_POP, SZ_L, 4'h5, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      rchk("pop value", 6'h14, 32'h8765_4321);
      rchk("sp pop", 6'h1c, 32'h80);
      rchk("flags pop", a_fl, 32'h28);
   endtask

   task automatic t_addr;
      logic [31:0] st;
      for (int k = 0; k < 4; k++)
      begin
         st = (k < 2) ? 32'(k + 1) : 32'h4;
         wr(6'h18, 32'h100);
         wr(a_fl, 32'h2f);
         go(OP_ADDR_ADD, SZ_L, 4'h6, 4'h0, 2'h0, 2'h0, 2'(k), 1);
         rchk("addr add", 6'h18, 32'h100 + st);
         go(OP_ADDR_SUB, SZ_L, 4'h6, 4'h0, 2'h0, 2'h0, 2'(k), 1);
         go(OP_ADDR_SUB, SZ_L, 4'h6, 4'h0, 2'h0, 2'h0, 2'(k), 1);
         rchk("addr sub", 6'h18, 32'h100 - st);
         rchk("flags addr", a_fl, 32'h2f);
      end
   endtask

   task automatic t_ind;
      logic [31:0] st;
      logic [31:0] ex;
      logic [3:0] ix;
      logic [3:0] iy;
      logic [31:0] ev [4];
      ev = '{32'h1234_56fc, 32'h1234_fffc, 32'h12ff_fffc, 32'hffff_fffc};
      wr(6'h04, 32'h1234_5678);
      for (int s = 0; s < 3; s++)
      begin
         st = (s == 0) ? 32'h1 : (s == 1) ? 32'h2 : 32'h4;
         ex = (s == 0) ? 32'h78 : (s == 1) ? 32'h5678 : 32'h1234_5678;
         ix = (s == 0) ? 4'h9 : 4'h1;
         iy = (s == 0) ? 4'hc : 4'h4;
         wr(6'h0c, 32'h40);
         wr(6'h10, 32'h0);
         go(OP_XFER_STORE, cta_size_e'(s), 4'h3, ix, 2'h2, 2'h0, 2'h0, 1);
         rchk("pre-dec", 6'h0c, 32'h40 - st);
         wr(a_fl, 32'h23);
         go(OP_XFER_LOAD, cta_size_e'(s), iy, 4'h3, 2'h2, 2'h0, 2'h0, 1);
         rchk("post-inc", 6'h0c, 32'h40);
         rchk("load value", 6'h10, ex);
         rchk("flags load", a_fl, 32'h21);
      end
      for (int f = 0; f < 4; f++)
      begin
         wr(6'h14, 32'h0);
         wr(a_ext, ev[f]);
         go(OP_XFER_LOAD, SZ_L, 4'h5, 4'h3, 2'h1, 2'(f), 2'h0, 1);
         rchk("disp load", 6'h14, 32'h1234_5678);
      end
      wr(6'h14, 32'h0);
      wr(a_ext, 32'h3c);
      go(OP_XFER_LOAD, SZ_L, 4'h5, 4'h0, 2'h3, 2'h0, 2'h0, 1);
      rchk("abs load", 6'h14, 32'h1234_5678);
   endtask

   task automatic t_multi;
      for (int n = 2; n < 5; n++)
      begin
         wr(6'h1c, 32'h80);
         for (int i = 0; i < n; i++)
            wr(6'(i * 4), 32'h1000_0001 + 32'(i));
         wr(a_fl, 32'h2f);
         go(OP_SAVE_MULTI, SZ_L, 4'(n - 1), 4'h0, 2'h0, 2'h0, 2'h0,
            3 + 2 * n);
         rchk("sp save", 6'h1c, 32'h80 - 32'(4 * n));
         rchk("flags save", a_fl, 32'h2f);
         go(OP_XFER_LOAD, SZ_L, 4'h5, 4'h7, 2'h0, 2'h0, 2'h0, 1);
         rchk("stack top", 6'h14, 32'h1000_0000 + 32'(n));
         for (int i = 0; i < n; i++)
            wr(6'(i * 4), 32'h0);
         go(OP_RESTORE_MULTI, SZ_L, 4'(n - 1), 4'h0, 2'h0, 2'h0, 2'h0,
            3 + 2 * n);
         rchk("sp restore", 6'h1c, 32'h80);
         for (int i = 0; i < n; i++)
            rchk("restored", 6'(i * 4), 32'h1000_0001 + 32'(i));
      end
   endtask

   task automatic mu(input cta_op_e op, input cta_size_e sz,
      input logic [3:0] s, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] ex, input logic [7:0] fi, input logic [7:0] fe,
      input int st);
      wr(6'h00, a);
      wr(6'h04, b);
      wr(a_fl, 32'(fi));
      go(op, sz, 4'h0, s, 2'h0, 2'h0, 2'h0, st);
      rchk("product", 6'h00, ex);
      rchk("flags mul", a_fl, 32'(fe));
   endtask

   // H and V are undefined after an adjust, so only N, Z and C are judged
   task automatic dj(input cta_op_e op, input logic [31:0] v,
      input logic [7:0] fi, input logic [31:0] ex, input logic [7:0] fe);
      logic [31:0] d;
      wr(6'h00, v);
      wr(a_fl, 32'(fi));
      go(op, SZ_B, 4'h8, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      rchk("adjusted", 6'h00, ex);
      rd(a_fl, d);
      chk("nzc adjust", 32'(fe), d & 32'h0d);
   endtask

   task automatic t_refuse;
      int n;
      wr(6'h00, 32'h5a);
      wr(a_cmd, {27'h0, OP_MUL_ACC});
      #1;
      chk("busy refused", 32'h0, {31'h0, busy});
      rchk("status ill", a_st, 32'h2);
      rchk("reg kept", 6'h00, 32'h5a);
      go(OP_NOP, SZ_B, 4'h0, 4'h0, 2'h0, 2'h0, 2'h0, 1);
      rchk("status clear", a_st, 32'h0);
      wr(6'h18, 32'h11);
      wr(a_cmd, {11'h0, 2'h0, 2'h0, 2'h0, 4'h1, 4'h2, SZ_W, OP_MUL_U});
      wr(6'h18, 32'h22);
      idle(n);
      chk("busy tail", 32'h12, 32'(n));
      rchk("write dropped", 6'h18, 32'h11);
   endtask

   // ==========================================
   // Run control
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Whole sequence needs about 650 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   initial
   begin
      rst_n = 1'h0;
      addr = 6'h0;
      wdata = 32'h0;
      wr_stb = 1'h0;
      rd_stb = 1'h0;
      n_errors = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      t_reset();
      t_move();
      t_addr();
      t_ind();
      t_multi();
      mu(OP_MUL_U, SZ_B, 4'h9, 32'hff, 32'h2, 32'h1fe,
         8'h2f, 8'h2f, 12);
      mu(OP_MUL_S, SZ_B, 4'h9, 32'hff, 32'h2, 32'hfffe,
         8'h23, 8'h2b, 13);
      mu(OP_MUL_U, SZ_W, 4'h1, 32'hffff, 32'h2, 32'h1fffe,
         8'h0, 8'h0, 20);
      mu(OP_MUL_S, SZ_W, 4'h1, 32'hffff, 32'h0, 32'h0,
         8'h29, 8'h25, 21);
      dj(OP_DEC_ADJ_ADD, 32'h45, 8'h00, 32'h45, 8'h00);
      dj(OP_DEC_ADJ_ADD, 32'h00, 8'h00, 32'h00, 8'h04);
      dj(OP_DEC_ADJ_ADD, 32'h0a, 8'h00, 32'h10, 8'h00);
      dj(OP_DEC_ADJ_ADD, 32'h45, 8'h01, 32'ha5, 8'h09);
      dj(OP_DEC_ADJ_SUB, 32'h99, 8'h00, 32'h99, 8'h08);
      dj(OP_DEC_ADJ_SUB, 32'h1f, 8'h20, 32'h19, 8'h00);
      t_refuse();
      end_sim();
   end

endmodule

`default_nettype wire
